/* File: fsd_dec_if.sv */
// Interface between the host controller and its sector decoder.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
interface fsd_dec_if;
  logic [6:0] addr_hi;
  logic       top_boot;
  logic       bank2;
  logic [4:0] sector;

  modport dec  (input addr_hi, input top_boot, output bank2, output sector);
  modport user (output addr_hi, output top_boot, input bank2, input sector);
endinterface

/* File: fsd_flash_model.sv */
// Behavioural model of the dual-bank flash pins.
// Assumes the bench resolves the shared data pins.
`timescale 1ns/1ns
module fsd_flash_model #(
  parameter int ACC_NS    = 90,
  parameter int RP_NS     = 500,
  parameter int NONALG_NS = 500,
  parameter int ALG_NS    = 700,
  parameter int BUSY_NS   = 4000
) (
  input  wire logic [18:0] addr_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        reset_n_in,
  input  wire logic        byte_n_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic             ready_busy_n_out
);
  logic [15:0] lat = 16'h0000;
  logic        busy = 1'b0;
  logic        was;
  wire         drv = !ce_n_in && !oe_n_in && reset_n_in;
  wire  [15:0] arr = byte_n_in ? addr_in[15:0] ^ 16'hA55A
                               : {8'h00, {addr_in[6:0], dq_in[15]} ^ 8'h5A};
  // ======
  // Latched data stays put while asleep; garbage until access time passes
  always @(arr) begin
    lat = ~lat;
    lat <= #(ACC_NS) arr;
  end
  assign dq_out[7:0]  = drv ? lat[7:0] : ~lat[7:0];
  assign dq_out[15:8] = !byte_n_in ? 8'hA5 : drv ? lat[15:8] : ~lat[15:8];
  assign ready_busy_n_out = !busy;
  always @(posedge we_n_in) if (reset_n_in) begin : alg
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
  always @(negedge reset_n_in) begin
    was = busy;
    #(RP_NS - 10);
    if (!reset_n_in) begin
      disable alg;
      busy = was;
      #((was ? ALG_NS : NONALG_NS) - RP_NS + 10);
      busy = 1'b0;
    end
  end
endmodule

/* File: fsd_host.sv */
// Host controller that drives a dual-bank parallel flash through its pins.
// Assumes an asynchronous device; pin inputs pass a three-stage synchroniser.
`timescale 1ns/1ns
module fsd_host #(
  parameter int READY_ALG_LIMIT = fsd_pkg::READY_ALG_CYC
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        REQ_IN,
  input  wire logic [1:0]  OP_IN,
  input  wire logic [19:0] ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        BYTE_MODE_IN,
  input  wire logic        TOP_BOOT_IN,
  output logic             READY_OUT,
  output logic             DONE_OUT,
  output logic [15:0]      RDATA_OUT,
  output logic             ABORTED_OUT,
  output logic             ASLEEP_OUT,
  output logic             BANK2_OUT,
  output logic [4:0]       SECTOR_OUT,
  output logic [18:0]      FL_ADDR_OUT,
  output logic             FL_CE_N_OUT,
  output logic             FL_OE_N_OUT,
  output logic             FL_WE_N_OUT,
  output logic             FL_RESET_N_OUT,
  output logic             FL_BYTE_N_OUT,
  input  wire logic [15:0] FL_DQ_IN,
  output logic [15:0]      FL_DQ_OUT,
  output logic [15:0]      FL_DQ_OE_OUT,
  input  wire logic        FL_READY_BUSY_N_IN
);
  import fsd_pkg::*;

  fsd_state_e  state_reg;
  fsd_state_e  state_next;
  logic [15:0] cnt_reg;
  logic [15:0] stable_cnt_reg;
  logic        was_busy_reg;
  logic        byte_reg;
  logic        rb_s1_reg;
  logic        rb_s2_reg;
  logic        rb_s3_reg;
  logic        rb_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  logic [15:0] dq_s3_reg;
  logic [15:0] dq_reg;
  logic [15:0] dq_now;
  logic        accept;
  logic [15:0] rst_limit;

  fsd_dec_if dec_if ();

  fsd_sector_dec u_dec (
    .CORE_CLK_IN (CORE_CLK_IN),
    .NRST_IN     (NRST_IN),
    .dec         (dec_if.dec)
  );

  assign dec_if.addr_hi  = FL_ADDR_OUT[18:12];
  assign dec_if.top_boot = TOP_BOOT_IN;
  assign BANK2_OUT       = dec_if.bank2;
  assign SECTOR_OUT      = dec_if.sector;

  assign accept    = REQ_IN && (state_reg == ST_IDLE);
  // Busy at reset means an algorithm was cut short, so allow the long wait
  assign rst_limit = was_busy_reg ? 16'(READY_ALG_LIMIT) : 16'(READY_NONALG_CYC); // [RL7] [RL8]
  // Value that counts this cycle, so a read ending now already takes fresh data
  assign dq_now    = (dq_s2_reg == dq_s3_reg) ? dq_s3_reg : dq_reg;

  // ==========================================================================
  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
      rb_s3_reg <= 1'b1;
      rb_reg    <= 1'b1;
    end else begin
      rb_s1_reg <= FL_READY_BUSY_N_IN;
      rb_s2_reg <= rb_s1_reg;
      rb_s3_reg <= rb_s2_reg;
      if (rb_s2_reg == rb_s3_reg)
        rb_reg <= rb_s3_reg;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
      dq_s3_reg <= 16'h0000;
      dq_reg    <= 16'h0000;
    end else begin
      dq_s1_reg <= FL_DQ_IN;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
      dq_reg    <= dq_now;
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          case (OP_IN)
            OP_READ:  state_next = ST_READ;
            OP_WRITE: state_next = ST_WRITE;
            OP_RESET: state_next = ST_RST_LOW;
            default:  state_next = ST_IDLE;
          endcase
        end
      end
      ST_READ:     if (cnt_reg >= 16'(ACC_CYC + SYNC_LAT_CYC)) state_next = ST_IDLE;
      ST_WRITE:    if (cnt_reg >= 16'(WP_CYC)) state_next = ST_WREC;
      ST_WREC:     if (cnt_reg >= 16'(WPH_CYC)) state_next = ST_IDLE;
      ST_RST_LOW:  if (cnt_reg >= 16'(RP_CYC)) state_next = ST_RST_WAIT; // [RL4] [RL22]
      ST_RST_WAIT: begin
        // Ready seen early ends the wait; the limit caps it
        if ((rb_reg && cnt_reg >= 16'(RP_CYC + SYNC_LAT_CYC)) || cnt_reg >= rst_limit)
          state_next = ST_RST_REC; // [RL10] [RL7] [RL8]
      end
      ST_RST_REC:  if (cnt_reg >= 16'(RH_CYC)) state_next = ST_IDLE; // [RL9]
      default:     state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Counter runs on across reset low and wait so the limit spans from assertion
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      cnt_reg <= 16'h0000;
    else if (state_next != state_reg && state_next != ST_RST_WAIT)
      cnt_reg <= 16'h0001;
    else if (cnt_reg != 16'hFFFF)
      cnt_reg <= 16'(cnt_reg + 16'h0001);
  end

  // ==========================================================================
  // Pin drive
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      FL_ADDR_OUT   <= 19'h00000;
      FL_DQ_OUT     <= 16'h0000;
      byte_reg      <= 1'b0;
      FL_BYTE_N_OUT <= 1'b1;
    end else if (accept) begin
      byte_reg      <= BYTE_MODE_IN;
      FL_BYTE_N_OUT <= !BYTE_MODE_IN;
      // Byte mode shifts the address down one and sends A-1 on the top data lane
      FL_ADDR_OUT   <= BYTE_MODE_IN ? ADDR_IN[19:1] : ADDR_IN[18:0]; // [RL18]
      FL_DQ_OUT     <= BYTE_MODE_IN ? {ADDR_IN[0], 7'h00, WDATA_IN[7:0]} : WDATA_IN; // [RL19]
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      FL_CE_N_OUT    <= 1'b1;
      FL_OE_N_OUT    <= 1'b1;
      FL_WE_N_OUT    <= 1'b1;
      FL_RESET_N_OUT <= 1'b1;
      FL_DQ_OE_OUT   <= DQ_OE_NONE;
    end else begin
      FL_CE_N_OUT    <= !(state_next == ST_READ || state_next == ST_WRITE);
      FL_OE_N_OUT    <= !(state_next == ST_READ);
      FL_WE_N_OUT    <= !(state_next == ST_WRITE);
      FL_RESET_N_OUT <= !(state_next == ST_RST_LOW); // [RL4]
      // Data lanes only driven while the device output is disabled, except the top lane, which carries A-1 in byte mode
      if (state_next == ST_WRITE || state_next == ST_WREC)
        FL_DQ_OE_OUT <= (accept ? BYTE_MODE_IN : byte_reg) ? DQ_OE_BYTE : DQ_OE_WORD; // [RL11]
      else if (accept ? BYTE_MODE_IN : byte_reg)
        FL_DQ_OE_OUT <= DQ_OE_ADDR; // [RL19]
      else
        FL_DQ_OE_OUT <= DQ_OE_NONE; // [RL11]
    end
  end

  // ==========================================================================
  // User side
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      READY_OUT <= 1'b0;
      DONE_OUT  <= 1'b0;
      RDATA_OUT <= 16'h0000;
    end else begin
      READY_OUT <= (state_next == ST_IDLE);
      DONE_OUT  <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
      // No command needed before a read once reset recovery is over
      if (state_reg == ST_READ && state_next == ST_IDLE)
        RDATA_OUT <= byte_reg ? {8'h00, dq_now[7:0]} : dq_now; // [RL5] [RL20]
    end
  end

  // Flags an aborted program or erase so the user can reissue it
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      was_busy_reg <= 1'b0;
      ABORTED_OUT  <= 1'b0;
    end else if (accept && OP_IN == OP_RESET) begin
      was_busy_reg <= !rb_reg;
      ABORTED_OUT  <= !rb_reg; // [RL6]
    end else if (accept) begin
      ABORTED_OUT  <= 1'b0;
    end
  end

  // Address-stable time tells when the device will have dropped to sleep;
  // control pins play no part, and read data stays valid meanwhile
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      stable_cnt_reg <= 16'h0000;
      ASLEEP_OUT     <= 1'b0;
    end else if (accept && (BYTE_MODE_IN ? ADDR_IN[19:1] : ADDR_IN[18:0]) != FL_ADDR_OUT) begin
      stable_cnt_reg <= 16'h0000; // [RL2]
      ASLEEP_OUT     <= 1'b0; // [RL3]
    end else begin
      if (stable_cnt_reg != 16'hFFFF)
        stable_cnt_reg <= 16'(stable_cnt_reg + 16'h0001);
      ASLEEP_OUT <= (stable_cnt_reg >= 16'(SLEEP_CYC)); // [RL1]
    end
  end
endmodule

/* File: fsd_host_asserts.sv */
// Pin checker for the flash host controller.
// Assumes it is bound to fsd_host and sees only its ports.
`timescale 1ns/1ns
module fsd_host_asserts
  import fsd_pkg::*;
(
  input wire logic        CORE_CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        REQ_IN,
  input wire logic [1:0]  OP_IN,
  input wire logic        TOP_BOOT_IN,
  input wire logic        READY_OUT,
  input wire logic        DONE_OUT,
  input wire logic        BANK2_OUT,
  input wire logic [4:0]  SECTOR_OUT,
  input wire logic [18:0] FL_ADDR_OUT,
  input wire logic        FL_CE_N_OUT,
  input wire logic        FL_OE_N_OUT,
  input wire logic        FL_WE_N_OUT,
  input wire logic        FL_RESET_N_OUT,
  input wire logic        FL_BYTE_N_OUT,
  input wire logic [15:0] FL_DQ_OE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ======
  // Helpers
  logic [7:0] lo_cnt_reg;
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      lo_cnt_reg <= 8'h00;
    else if (FL_RESET_N_OUT)
      lo_cnt_reg <= 8'h00;
    else
      lo_cnt_reg <= 8'(lo_cnt_reg + 8'h01);
  end
  // Own decode, kept apart from the design's so a shared slip shows
  function automatic logic [4:0] exp_sec(input logic [6:0] a, input logic top);
    logic [4:0] s;
    case ({a[3], a[2:1]})
      3'h0: s = 5'h00;
      3'h3: s = {4'h1, a[0]};
      3'h4: s = {4'h2, a[0]};
      3'h7: s = 5'h07;
      3'h1, 3'h2: s = 5'h01;
      default: s = 5'h06;
    endcase
    if (a[6:4] != (top ? 3'h7 : 3'h0)) s = top ? {1'b0, a[6:3]} : {1'b0, a[6:3]} + 5'h06;
    else if (top) s = s + 5'h0E;
    return s;
  endfunction
  sequence s_take_rd;
    REQ_IN && READY_OUT && OP_IN == OP_READ;
  endsequence
  // ======
  // Checks
  chk_read_strobe: assert property (s_take_rd |=> !FL_CE_N_OUT && !FL_OE_N_OUT
    && FL_WE_N_OUT && FL_RESET_N_OUT) else $error("read strobes wrong");
  chk_read_time: assert property (s_take_rd |-> ##27 DONE_OUT)
    else $error("read not done in time");
  chk_oe_dq_free: assert property (!FL_OE_N_OUT |-> FL_DQ_OE_OUT[14:0] == 15'h0000
    && (!FL_DQ_OE_OUT[15] || !FL_BYTE_N_OUT)) else $error("host drives data while reading");
  chk_byte_lanes: assert property (!FL_BYTE_N_OUT && !FL_CE_N_OUT |->
    FL_DQ_OE_OUT[15] && FL_DQ_OE_OUT[14:8] == 7'h00) else $error("byte lanes wrong");
  chk_rst_width: assert property ($rose(FL_RESET_N_OUT) |-> lo_cnt_reg == RP_CYC)
    else $error("reset pulse width wrong");
  chk_rst_recover: assert property ($rose(FL_RESET_N_OUT) |-> not (##[0:11] DONE_OUT))
    else $error("reset recovery too short");
  chk_rst_bound: assert property ($rose(FL_RESET_N_OUT) |-> ##[12:200] DONE_OUT)
    else $error("reset never finished");
  chk_sector_map: assert property ($past(NRST_IN) |->
    SECTOR_OUT == exp_sec($past(FL_ADDR_OUT[18:12]), $past(TOP_BOOT_IN))) else $error("sector wrong");
  chk_bank_map: assert property ($past(NRST_IN) |-> BANK2_OUT ==
    ($past(FL_ADDR_OUT[18:16]) != ($past(TOP_BOOT_IN) ? 3'h7 : 3'h0))) else $error("bank wrong");
endmodule
bind fsd_host fsd_host_asserts chk_u (.CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN),
  .REQ_IN(REQ_IN), .OP_IN(OP_IN), .TOP_BOOT_IN(TOP_BOOT_IN), .READY_OUT(READY_OUT),
  .DONE_OUT(DONE_OUT), .BANK2_OUT(BANK2_OUT), .SECTOR_OUT(SECTOR_OUT),
  .FL_ADDR_OUT(FL_ADDR_OUT), .FL_CE_N_OUT(FL_CE_N_OUT), .FL_OE_N_OUT(FL_OE_N_OUT),
  .FL_WE_N_OUT(FL_WE_N_OUT), .FL_RESET_N_OUT(FL_RESET_N_OUT),
  .FL_BYTE_N_OUT(FL_BYTE_N_OUT), .FL_DQ_OE_OUT(FL_DQ_OE_OUT));

/* File: fsd_host_bench.sv */
// Self-checking bench for the flash host controller.
// Assumes the flash model on the pins and the bound checker.
`timescale 1ns/1ns
module fsd_host_bench;
  import fsd_pkg::*;
  logic clk, nrst, req, bm, top, rdy, done, abrt, slp, ce_n, oe_n, we_n, frst_n, byte_n, rb_n;
  logic [1:0]  op;
  logic [19:0] addr;
  logic [18:0] fa;
  logic [15:0] wd, rdata, dq_o, dq_oe, dev_dq;
  wire  [15:0] dq_i = (dq_oe & dq_o) | (~dq_oe & dev_dq);
  int          error_cnt = 0;
  int          samples_checked = 0;
  fsd_host #(.READY_ALG_LIMIT(200)) dut_u (.CORE_CLK_IN(clk), .NRST_IN(nrst), .REQ_IN(req),
    .OP_IN(op), .ADDR_IN(addr), .WDATA_IN(wd), .BYTE_MODE_IN(bm), .TOP_BOOT_IN(top),
    .READY_OUT(rdy), .DONE_OUT(done), .RDATA_OUT(rdata), .ABORTED_OUT(abrt),
    .ASLEEP_OUT(slp), .BANK2_OUT(), .SECTOR_OUT(), .FL_ADDR_OUT(fa), .FL_CE_N_OUT(ce_n),
    .FL_OE_N_OUT(oe_n), .FL_WE_N_OUT(we_n), .FL_RESET_N_OUT(frst_n), .FL_BYTE_N_OUT(byte_n),
    .FL_DQ_IN(dq_i), .FL_DQ_OUT(dq_o), .FL_DQ_OE_OUT(dq_oe), .FL_READY_BUSY_N_IN(rb_n));
  fsd_flash_model model_u (.addr_in(fa), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .reset_n_in(frst_n), .byte_n_in(byte_n), .dq_in(dq_i), .dq_out(dev_dq),
    .ready_busy_n_out(rb_n));
  // ======
  // Shared tasks
  task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    chk_val(nm, {15'h0000, exp}, {15'h0000, got});
  endtask
  // Waits on DONE with a bound, so a stuck design cannot hang the run
  task automatic run_op(input logic [1:0] o, input logic [19:0] a, input logic b, input logic t);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    op <= o;
    addr <= a;
    bm <= b;
    top <= t;
    wd <= ~a[15:0];
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 3000);
    chk_flag("done", 1'b1, done);
    chk_flag("ready", 1'b1, rdy);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ======
  // Scenarios
  task automatic t_word_sweep;
    logic [19:0] a;
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 128; s++) begin
        a = {1'b0, s[6:0], s[6:0], 5'h15};
        run_op(OP_READ, a, 1'b0, t[0]);
        chk_val("word_data", a[15:0] ^ 16'hA55A, rdata);
      end
    end
  endtask
  task automatic t_byte_read;
    for (int i = 0; i < 4; i++) begin
      run_op(OP_READ, {16'hE7C5, i[3:0]}, 1'b1, 1'b0);
      chk_val("byte_data", {8'h00, {4'h5, i[3:0]} ^ 8'h5A}, rdata);
    end
  endtask
  task automatic t_sleep;
    run_op(OP_READ, 20'h12345, 1'b0, 1'b1);
    chk_flag("asleep", 1'b0, slp);
    repeat (40) @(posedge clk);
    #1;
    chk_flag("asleep", 1'b1, slp);
    run_op(OP_READ, 20'h54321, 1'b0, 1'b1);
    chk_val("wake_data", 16'h4321 ^ 16'hA55A, rdata);
    chk_flag("asleep", 1'b0, slp);
  endtask
  task automatic t_rst_idle;
    run_op(OP_RESET, 20'h00000, 1'b0, 1'b0);
    chk_flag("aborted", 1'b0, abrt);
    run_op(OP_READ, 20'h0ABCD, 1'b0, 1'b0);
    chk_val("post_rst", 16'hABCD ^ 16'hA55A, rdata);
  endtask
  task automatic t_rst_busy;
    run_op(OP_WRITE, 20'h01234, 1'b0, 1'b0);
    run_op(OP_RESET, 20'h01234, 1'b0, 1'b0);
    chk_flag("aborted", 1'b1, abrt);
    run_op(OP_WRITE, 20'h01234, 1'b0, 1'b0);
    chk_flag("aborted", 1'b0, abrt);
  endtask
  // ======
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {nrst, req, bm, top, op, addr, wd} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_word_sweep();
    t_byte_read();
    t_sleep();
    t_rst_idle();
    t_rst_busy();
    close_out();
  end
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule

/* File: fsd_pkg.sv */
// Constants, timing counts and sector decoding for the flash host controller.
// Assumes a 250 MHz core clock; every pin timing is counted in its cycles.
// Function
// [RL1] Device sleeps after address stable access+30ns
// [RL2] Sleep depends only on address stability
// [RL3] Sleeping device keeps driving latched data
// [RL4] Held reset aborts, tri-states, ignores commands
// [RL5] Hardware reset returns device to read-array
// [RL6] Host reissues operation aborted by reset
// [RL7] Reset during algorithm keeps busy until ready
// [RL8] Idle reset completes within shorter ready time
// [RL9] Host waits recovery time before reading
// [RL10] Host may poll ready/busy for reset end
// [RL11] Output-enable high tri-states device data pins
// [RL12] Top boot: bank 111 is bank one
// [RL13] Top bank one, A15 low sector map
// [RL14] Top bank one, A15 high sector map
// [RL15] Bottom boot: bank 000 is bank one
// [RL16] Bottom bank one, A15 low sector map
// [RL17] Bottom bank one, A15 high sector map
// [RL18] Byte mode adds A-1 below A0
// [RL19] Byte mode: upper lanes idle, top lane A-1
// [RL20] Power-up and reset enter read-array state
// [RL21] Device timings kept as named parameters
// [RL22] Short reset pulse may be ignored
package fsd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 4;
  localparam int T_ACC_NS            = 90; // [RL21]
  localparam int T_SLEEP_EXTRA_NS    = 30;
  localparam int T_WP_NS             = 35;
  localparam int T_WPH_NS            = 30;
  localparam int T_RP_NS             = 500;
  localparam int T_RH_NS             = 50;
  localparam int T_READY_NONALG_NS   = 500;
  localparam int T_READY_ALG_NS      = 20000;
  localparam int SYNC_LAT_CYC        = 3;

  // Least times round up
  localparam int ACC_CYC   = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CYC = (T_ACC_NS + T_SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC    = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC   = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC    = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC    = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest waits round down
  localparam int READY_NONALG_CYC = T_READY_NONALG_NS / CLK_PERIOD_NS;
  localparam int READY_ALG_CYC    = T_READY_ALG_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Commands and pin enables
  localparam logic [1:0]  OP_READ      = 2'h0;
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_RESET     = 2'h2;
  localparam logic [15:0] DQ_OE_WORD   = 16'hFFFF;
  localparam logic [15:0] DQ_OE_BYTE   = 16'h80FF;
  localparam logic [15:0] DQ_OE_ADDR   = 16'h8000;
  localparam logic [15:0] DQ_OE_NONE   = 16'h0000;
  localparam logic [4:0]  TOP_B1_BASE  = 5'h0E;
  localparam logic [4:0]  BOT_B2_BASE  = 5'h06;
  localparam logic [2:0]  TOP_B1_CODE  = 3'h7;
  localparam logic [2:0]  BOT_B1_CODE  = 3'h0;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_READ     = 7'b0000010,
    ST_WRITE    = 7'b0000100,
    ST_WREC     = 7'b0001000,
    ST_RST_LOW  = 7'b0010000,
    ST_RST_WAIT = 7'b0100000,
    ST_RST_REC  = 7'b1000000
  } fsd_state_e;

  // ==========================================================================
  // Sector decoding; a holds A18:A12
  function automatic logic is_bank1(input logic [6:0] a, input logic top);
    is_bank1 = top ? (a[6:4] == TOP_B1_CODE) : (a[6:4] == BOT_B1_CODE); // [RL12] [RL15]
  endfunction

  function automatic logic [4:0] sector_of(input logic [6:0] a, input logic top);
    logic [4:0] sub;
    sub = 5'h00;
    if (!a[3]) begin
      case (a[2:1])
        2'b00:   sub = 5'h00;                   // [RL13] [RL16]
        2'b11:   sub = {4'h1, a[0]};            // [RL13] [RL16]
        default: sub = 5'h01;                   // [RL13] [RL16]
      endcase
    end else begin
      case (a[2:1])
        2'b00:   sub = {4'h2, a[0]};            // [RL14] [RL17]
        2'b11:   sub = 5'h07;                   // [RL14] [RL17]
        default: sub = 5'h06;                   // [RL14] [RL17]
      endcase
    end
    if (is_bank1(a, top))
      sector_of = top ? 5'(sub + TOP_B1_BASE) : sub;
    else
      sector_of = top ? {1'b0, a[6:3]} : 5'({1'b0, a[6:3]} + BOT_B2_BASE); // [RL12] [RL15]
  endfunction

endpackage

/* File: fsd_sector_dec.sv */
// Registered bank and sector decoder for the flash address pins.
// Assumes addr_hi carries A18:A12 as driven on the pins.
`timescale 1ns/1ns
module fsd_sector_dec (
  input  wire logic CORE_CLK_IN,
  input  wire logic NRST_IN,
  fsd_dec_if.dec    dec
);
  import fsd_pkg::*;

  // ==========================================================================
  // Decode
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dec.bank2  <= 1'b0;
      dec.sector <= 5'h00;
    end else begin
      dec.bank2  <= !is_bank1(dec.addr_hi, dec.top_boot);     // [RL12] [RL15]
      dec.sector <= sector_of(dec.addr_hi, dec.top_boot);
    end
  end
endmodule
